// *** src/timer_irq_vector_and_clock_divider.v ***
// Purpose: Interrupt vector, channel flags and input divider of a timer
// Assumes: Event inputs are one-cycle pulses from logic on aclk
// Notes: Registers sit on an AXI4-Lite slave, fields in the low byte
// Notes on behaviour
// - The 16-bit read-only vector resets to zero and reads zero when nothing is pending.
// - A pending channel 1 flag reads as 02h and beats every other source.
// - Channels 2 to 6 read as 04h to 0Ch, the lower channel winning.
// - A pending overflow reads as 0Eh and only when no channel is pending.
// - Bits 15 to 3 of the expansion register ignore writes and read zero.
// - The 3-bit expansion field resets to zero and value k divides by k plus one.
// - The applied division is the basic divider times the expansion divider.
// - A channel's flag enters the vector only when its enable at bit 4 is set; irq follows status and mask.
`timescale 1ns/1ps
`include "timer_irq_consts.vh"
module timer_irq_vector_and_clock_divider
(
    input wire aclk, // Timer clock, 100 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [7:0] awaddr, // Write address
    input wire [2:0] awprot, // Write protection, unused
    input wire awvalid, // Write address valid
    output reg awready, // Write address ready
    input wire [31:0] wdata, // Write data
    input wire [3:0] wstrb, // Write byte strobes
    input wire wvalid, // Write data valid
    output reg wready, // Write data ready
    output reg [1:0] bresp, // Write response
    output reg bvalid, // Write response valid
    input wire bready, // Write response ready
    input wire [7:0] araddr, // Read address
    input wire [2:0] arprot, // Read protection, unused
    input wire arvalid, // Read address valid
    output reg arready, // Read address ready
    output reg [31:0] rdata, // Read data
    output reg [1:0] rresp, // Read response
    output reg rvalid, // Read data valid
    input wire rready, // Read data ready
    input wire [5:0] channel_event, // Channel 1..6 event pulses
    input wire overflow_event, // Counter overflow pulse
    output reg irq, // Level interrupt
    output wire timer_tick // Divided timer clock tick, registered
);

localparam NUM_CHAN = 6;

reg aw_have;
reg w_have;
reg [7:0] wr_addr;
reg [31:0] wr_data;
reg [3:0] wr_strb;
reg ovf_ie;
reg ovf_flag;
reg run;
reg clear_pulse;
reg [1:0] basic_div;
reg [2:0] expand_div;
wire [5:0] chan_ie;
wire [5:0] chan_flag;
reg [6:0] status;
reg [6:0] mask;
reg [15:0] rd_word;
integer ri;

function [7:0] chan_ofs;
    input [2:0] n;
    begin
        chan_ofs = `OFS_CHAN_BASE + {3'h0, n, 2'h0};
    end
endfunction

function addr_mapped;
    input [7:0] a;
    integer i;
    begin
        addr_mapped = (a == `OFS_CONTROL) || (a == `OFS_VECTOR) ||
            (a == `OFS_EXPANSION) || (a == `OFS_STATUS) ||
            (a == `OFS_MASK);
        for (i = 0; i < NUM_CHAN; i = i + 1)
        begin
            if (a == chan_ofs(i[2:0]))
            begin
                addr_mapped = 1'b1;
            end
        end
    end
endfunction

// Walk from lowest priority upward so the last match is the winner
function [15:0] vector_code;
    input [6:0] p;
    integer i;
    reg [3:0] code;
    begin
        code = 4'h0;
        vector_code = `VEC_NONE;
        if (p[6])
        begin
            vector_code = `VEC_OVF;
        end
        for (i = NUM_CHAN - 1; i >= 0; i = i - 1)
        begin
            if (p[i])
            begin
                code = i[3:0] + 4'h1;
                vector_code = {11'h000, code, 1'b0};
            end
        end
    end
endfunction

wire do_write = aw_have & w_have & ~bvalid;
wire lane0 = wr_strb[0];
wire rd_take = arvalid & arready;
wire wr_ctl = do_write & lane0 & (wr_addr == `OFS_CONTROL);
wire wr_exp = do_write & lane0 & (wr_addr == `OFS_EXPANSION);
wire wr_mask = do_write & lane0 & (wr_addr == `OFS_MASK);
wire [6:0] pend = {ovf_flag & ovf_ie, chan_flag & chan_ie};
// Bit order equals priority order, so the lowest set bit is the winner
wire [6:0] pend_first = pend & (~pend + 7'h01);
wire vec_read = rd_take & (araddr == `OFS_VECTOR);
wire [6:0] vec_clear = vec_read ? pend_first : 7'h00;
wire stat_read = rd_take & (araddr == `OFS_STATUS);
wire [6:0] events = {overflow_event, channel_event};

// Write channel: address and data are taken in either order
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        wr_addr <= 8'h00;
        wr_data <= 32'h0000_0000;
        wr_strb <= 4'h0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
    end
    else
    begin
        if (awvalid && awready)
        begin
            aw_have <= 1'b1;
            wr_addr <= awaddr;
            awready <= 1'b0;
        end
        if (wvalid && wready)
        begin
            w_have <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
            wready <= 1'b0;
        end
        if (do_write)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            bvalid <= 1'b1;
            bresp <= addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid && bready)
        begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end
    end
end

always @*
begin
    rd_word = 16'h0000;
    if (araddr == `OFS_CONTROL)
    begin
        rd_word = {8'h00, basic_div, 1'b0, run, 2'h0, ovf_flag, ovf_ie};
    end
    else if (araddr == `OFS_VECTOR)
    begin
        rd_word = vector_code(pend);
    end
    else if (araddr == `OFS_EXPANSION)
    begin
        rd_word = {13'h0000, expand_div};
    end
    else if (araddr == `OFS_STATUS)
    begin
        rd_word = {9'h000, status};
    end
    else if (araddr == `OFS_MASK)
    begin
        rd_word = {9'h000, mask};
    end
    else
    begin
        for (ri = 0; ri < NUM_CHAN; ri = ri + 1)
        begin
            if (araddr == chan_ofs(ri[2:0]))
            begin
                rd_word = {11'h000, chan_ie[ri], 3'h0, chan_flag[ri]};
            end
        end
    end
end

// Read channel: data and side effects belong to the address handshake
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        arready <= 1'b1;
        rvalid <= 1'b0;
        rdata <= 32'h0000_0000;
        rresp <= `RESP_OKAY;
    end
    else
    begin
        if (rd_take)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_word};
            rresp <= addr_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
end

// Control: overflow flag and enable, run, basic divider, clear strobe
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ovf_ie <= 1'b0;
        ovf_flag <= 1'b0;
        run <= 1'b0;
        basic_div <= `DIV_BASIC_RESET;
        clear_pulse <= 1'b0;
    end
    else if (wr_ctl)
    begin
        ovf_ie <= wr_data[`CTL_OVF_IE];
        // A new overflow wins over a software clear
        ovf_flag <= wr_data[`CTL_OVF_FLAG] | overflow_event;
        run <= wr_data[`CTL_RUN];
        basic_div <= wr_data[`CTL_DIV_MSB:`CTL_DIV_LSB];
        clear_pulse <= wr_data[`CTL_CLEAR];
    end
    else
    begin
        ovf_flag <= overflow_event | (ovf_flag & ~vec_clear[6]);
        clear_pulse <= 1'b0;
    end
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        expand_div <= `DIV_EXP_RESET;
    end
    else if (wr_exp)
    begin
        expand_div <= wr_data[`EXP_MSB:`EXP_LSB];
    end
end

// One slice per channel: enable, flag and its own write decode
genvar gc;
generate
    for (gc = 0; gc < NUM_CHAN; gc = gc + 1)
    begin : g_chan
        reg ie_bit;
        reg flag_bit;
        wire wr_this = do_write & lane0 &
            (wr_addr == `OFS_CHAN_BASE + 4 * gc);
        always @(posedge aclk)
        begin
            if (!aresetn)
            begin
                ie_bit <= 1'b0;
                flag_bit <= 1'b0;
            end
            else if (wr_this)
            begin
                ie_bit <= wr_data[`CCTL_IE];
                flag_bit <= wr_data[`CCTL_FLAG] | channel_event[gc];
            end
            else
            begin
                // Event in the clearing cycle keeps the flag set
                flag_bit <= channel_event[gc] |
                    (flag_bit & ~vec_clear[gc]);
            end
        end
        assign chan_ie[gc] = ie_bit;
        assign chan_flag[gc] = flag_bit;
    end
endgenerate

// Sticky event summary: a read returns it, then clears it
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        status <= `EVT_RESET;
        mask <= `EVT_RESET;
        irq <= 1'b0;
    end
    else
    begin
        status <= events | (status & (stat_read ? 7'h00 : 7'h7F));
        if (wr_mask)
        begin
            mask <= wr_data[6:0];
        end
        irq <= |(status & mask);
    end
end

// Clear restarts both divider stages but keeps their settings
clock_divider #(
    .CNT_W(3)
) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .clear(clear_pulse),
    .basic_sel(basic_div),
    .expand_sel(expand_div),
    .tick(timer_tick)
);

endmodule // timer_irq_vector_and_clock_divider

// *** src/timer_irq_consts.vh ***
// Purpose: Shared constants for the timer interrupt vector and divider
// Assumes: Included by bare name from the design files
// Notes: Offsets are byte addresses on the register bus
`ifndef TIMER_IRQ_CONSTS_VH
`define TIMER_IRQ_CONSTS_VH

`define OFS_CONTROL 8'h00
`define OFS_CHAN_BASE 8'h10
`define OFS_VECTOR 8'h30
`define OFS_EXPANSION 8'h34
`define OFS_STATUS 8'h38
`define OFS_MASK 8'h3C

`define CTL_OVF_IE 0
`define CTL_OVF_FLAG 1
`define CTL_CLEAR 2
`define CTL_RUN 4
`define CTL_DIV_LSB 6
`define CTL_DIV_MSB 7

`define CCTL_FLAG 0
`define CCTL_IE 4

`define EXP_LSB 0
`define EXP_MSB 2

`define VEC_NONE 16'h0000
`define VEC_OVF 16'h000E

`define DIV_BASIC_RESET 2'h0
`define DIV_EXP_RESET 3'h0
`define EVT_RESET 7'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** src/clock_divider.v ***
// Purpose: Two-stage input clock divider producing a one-cycle tick
// Assumes: Both selections are held steady while the timer runs
// Notes: Ratio is (1 << basic_sel) * (expand_sel + 1)
`timescale 1ns/1ps
`include "timer_irq_consts.vh"
module clock_divider
#(
    parameter CNT_W = 3
)
(
    input wire aclk, // Timer clock
    input wire aresetn, // Synchronous reset, active low
    input wire run, // Counting enabled
    input wire clear, // One-cycle clear of both divider counters
    input wire [1:0] basic_sel, // Basic divider: 1, 2, 4 or 8
    input wire [2:0] expand_sel, // Expansion divider: k + 1
    output reg tick // One-cycle pulse at the divided rate
);

reg [CNT_W-1:0] pre_cnt;
reg [2:0] post_cnt;
reg [CNT_W-1:0] pre_limit;
wire pre_tick;

always @*
begin
    case (basic_sel)
        2'h0: pre_limit = 3'h0;
        2'h1: pre_limit = 3'h1;
        2'h2: pre_limit = 3'h3;
        default: pre_limit = 3'h7;
    endcase
end

// Compare with >= so a smaller setting mid-count cannot wrap the counter
assign pre_tick = run & (pre_cnt >= pre_limit);

always @(posedge aclk)
begin
    if (!aresetn || clear)
    begin
        pre_cnt <= {CNT_W{1'b0}};
        post_cnt <= 3'h0;
        tick <= 1'b0;
    end
    else
    begin
        tick <= 1'b0;
        if (run)
        begin
            if (pre_tick)
            begin
                pre_cnt <= {CNT_W{1'b0}};
            end
            else
            begin
                pre_cnt <= pre_cnt + 3'h1;
            end
        end
        if (pre_tick)
        begin
            if (post_cnt >= expand_sel)
            begin
                post_cnt <= 3'h0;
                tick <= 1'b1;
            end
            else
            begin
                post_cnt <= post_cnt + 3'h1;
            end
        end
    end
end

endmodule // clock_divider

// *** bench/timer_irq_monitor.sv ***
// Purpose: Bus and field checks on the timer register port
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the top module, ports matched by name
`timescale 1ns/1ps
`include "timer_irq_consts.vh"
module timer_irq_monitor
(
    input wire aclk, // Clock
    input wire aresetn, // Reset, active low
    input wire awvalid, // AW valid
    input wire awready, // AW ready
    input wire wvalid, // W valid
    input wire wready, // W ready
    input wire bvalid, // B valid
    input wire bready, // B ready
    input wire arvalid, // AR valid
    input wire arready, // AR ready
    input wire [7:0] araddr, // Read address
    input wire rvalid, // R valid
    input wire rready, // R ready
    input wire [31:0] rdata, // Read data
    input wire [1:0] rresp // Read response
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        arvalid && arready;
    endsequence
    sequence wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence b_answer;
        !awready ##1 bvalid;
    endsequence
    a_read_answer: assert property (ar_take |=> rvalid && !arready)
        else $error("read answer missing");
    a_write_answer: assert property (wr_take |=> b_answer)
        else $error("write answer missing");
    a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped early");
    a_rdata_holds: assert property (!(arvalid && arready)
        |=> $stable(rdata))
        else $error("read data moved");
    a_vector_width: assert property (rvalid |-> rdata[31:16] == 0)
        else $error("upper read bits set");
    a_vector_codes: assert property (arvalid && arready
        && araddr == `OFS_VECTOR |=> rdata[15:4] == 0 && !rdata[0])
        else $error("vector code malformed");
    a_expand_reserved: assert property (arvalid && arready
        && araddr == `OFS_EXPANSION |=> rdata[15:3] == 0)
        else $error("reserved bits set");
    a_unmapped_err: assert property (arvalid && arready
        && araddr == 8'h28 |=> rresp == `RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule // timer_irq_monitor

bind timer_irq_vector_and_clock_divider timer_irq_monitor mon (.*);

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for timer vector and divider
// Assumes: Bench speaks AXI4-Lite to the register port
// Notes: Events are pulsed for one cycle
`timescale 1ns/1ps
`include "timer_irq_consts.vh"
module testbench;
    reg aclk = 0;
    reg aresetn = 0;
    reg [7:0] awaddr = 0;
    reg [2:0] awprot = 0;
    reg awvalid = 0;
    reg [31:0] wdata = 0;
    reg [3:0] wstrb = 4'hF;
    reg wvalid = 0;
    reg bready = 0;
    reg [7:0] araddr = 0;
    reg [2:0] arprot = 0;
    reg arvalid = 0;
    reg rready = 0;
    reg [5:0] channel_event = 0;
    reg overflow_event = 0;
    wire awready, wready, bvalid, arready, rvalid, irq, timer_tick;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer miscompares = 0;
    integer check_count = 0;
    integer i, n;
    reg [31:0] rval;
    reg [1:0] rstat;
    reg ta, tw, tb;
    timer_irq_vector_and_clock_divider dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awprot(awprot),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arprot(arprot),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .channel_event(channel_event),
        .overflow_event(overflow_event),
        .irq(irq),
        .timer_tick(timer_tick)
    );
    always #5 aclk = ~aclk;
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task hang;
        begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task write_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            tb = 0;
            for (n = 0; n < 40 && !tb; n = n + 1)
            begin
                @(negedge aclk);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bvalid;
                rstat = bresp;
                @(posedge aclk);
                if (ta) awvalid <= 0;
                if (tw) wvalid <= 0;
            end
            bready <= 0;
            if (!tb) hang;
        end
    endtask
    task read_reg(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            tb = 0;
            for (n = 0; n < 40 && !tb; n = n + 1)
            begin
                @(negedge aclk);
                ta = arvalid && arready;
                tb = rvalid;
                rval = rdata;
                rstat = rresp;
                @(posedge aclk);
                if (ta) arvalid <= 0;
            end
            rready <= 0;
            if (!tb) hang;
        end
    endtask
    task pulse(input [5:0] c, input o);
        begin
            @(posedge aclk);
            channel_event <= c;
            overflow_event <= o;
            @(posedge aclk);
            channel_event <= 0;
            overflow_event <= 0;
        end
    endtask
    task wait_tick(output integer k);
        begin
            k = 0;
            do
            begin
                @(negedge aclk);
                k = k + 1;
            end
            while (timer_tick !== 1'b1 && k < 200);
            if (timer_tick !== 1'b1) hang;
        end
    endtask
    task t_reset;
        begin
            read_reg(`OFS_VECTOR);
            check(rval, 0, "vector");
            read_reg(`OFS_EXPANSION);
            check(rval, 0, "expand");
            read_reg(8'h28);
            check(rstat, `RESP_SLVERR, "resp");
            write_reg(8'h28, 32'h0000_0001);
            check(rstat, `RESP_SLVERR, "bresp");
            $display("reset test done");
        end
    endtask
    task t_expand;
        begin
            write_reg(`OFS_EXPANSION, 32'h0000_FFFD);
            check(rstat, `RESP_OKAY, "bresp");
            read_reg(`OFS_EXPANSION);
            check(rval, 32'h0000_0005, "expand");
            $display("expansion test done");
        end
    endtask
    task t_vector;
        begin
            write_reg(`OFS_MASK, 32'h0000_007F);
            write_reg(`OFS_CONTROL, 32'h0000_0001);
            for (i = 0; i < 6; i = i + 1)
                write_reg(`OFS_CHAN_BASE + 4 * i, 32'h0000_0010);
            pulse(6'h3F, 1'b1);
            repeat (2) @(negedge aclk);
            check(irq, 1, "irq");
            for (i = 1; i < 8; i = i + 1)
            begin
                read_reg(`OFS_VECTOR);
                check(rval, 2 * i, "vector");
            end
            read_reg(`OFS_VECTOR);
            check(rval, 0, "vector");
            read_reg(`OFS_STATUS);
            check(rval, 32'h0000_007F, "status");
            repeat (2) @(negedge aclk);
            check(irq, 0, "irq");
            // Channel 1 disabled must not mask the enabled channel 2
            write_reg(`OFS_CHAN_BASE, 32'h0000_0000);
            pulse(6'h03, 1'b0);
            read_reg(`OFS_VECTOR);
            check(rval, 32'h0000_0004, "vector");
            read_reg(`OFS_VECTOR);
            check(rval, 0, "vector");
            // Channel 1 and 2 events still sit in status, mask decides
            check(irq, 1, "irq");
            write_reg(`OFS_MASK, 32'h0000_0000);
            repeat (2) @(negedge aclk);
            check(irq, 0, "irq");
            $display("vector test done");
        end
    endtask
    task div_case(input [1:0] b, input [2:0] k);
        begin
            write_reg(`OFS_EXPANSION, {29'h0, k});
            write_reg(`OFS_CONTROL, {24'h0, b, 6'h15});
            wait_tick(n);
            wait_tick(n);
            check(n, (1 << b) * (k + 1), "period");
        end
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_expand;
        t_vector;
        div_case(2'h1, 3'h2);
        div_case(2'h3, 3'h7);
        div_case(2'h0, 3'h0);
        $display("divider test done");
        tally_and_finish;
    end
endmodule // testbench
